//--- mpt_partner.sv
`timescale 1ns/1ps
module mpt_partner
(
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_start_req,
  output logic ext_clk_pin,
  output logic [7:0] adc_cnt
);
  initial ext_clk_pin = 1'b0;
  // Converter side only tallies start requests
  always_ff @(posedge clk)
    if (rst)
      adc_cnt <= 8'h00;
    else if (adc_start_req === 1'b1)
      adc_cnt <= adc_cnt + 8'h01;
  // Minimum widths only, the hardest case for the sampler
  task automatic pulses(input int n, input int w);
    repeat (n)
    begin
      repeat (w) @(posedge clk);
      ext_clk_pin <= 1'b1;
      repeat (w) @(posedge clk);
      ext_clk_pin <= 1'b0;
    end
  endtask
endmodule

//--- mpt_pkg.sv
package mpt_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NCH = 2;
  localparam int unsigned NPIN = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_START = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_LVL1 = 8'h08;
  localparam logic [7:0] OFS_LVL2 = 8'h0c;
  localparam logic [7:0] OFS_CMPA = 8'h10;
  localparam logic [7:0] OFS_ADCA = 8'h14;
  localparam logic [7:0] OFS_ADCB = 8'h18;
  localparam logic [7:0] OFS_DEAD = 8'h1c;
  localparam logic [7:0] OFS_HIZ1 = 8'h20;
  localparam logic [7:0] OFS_HIZ2 = 8'h24;
  localparam logic [7:0] OFS_CLKSEL = 8'h28;
  localparam logic [7:0] OFS_STAT = 8'h2c;
  localparam logic [7:0] OFS_MASK = 8'h30;
  localparam logic [7:0] OFS_CNT3 = 8'h34;
  localparam logic [7:0] OFS_CNT4 = 8'h38;
  localparam logic [7:0] OFS_SUBC = 8'h3c;
  // Mode field values
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_COMP_PWM = 2'h1;
  localparam logic [1:0] MODE_RSYNC_PWM = 2'h2;
  // Status bits
  localparam int unsigned ST_TROUGH = 0;
  localparam int unsigned ST_ADCA = 1;
  localparam int unsigned ST_ADCB = 2;
  localparam int unsigned ST_HIZ = 3;
  localparam int unsigned NSTAT = 4;
  // Minimum external clock pulse widths, in peripheral clock periods
  localparam int unsigned EXT_MIN_SINGLE = 3;
  localparam int unsigned EXT_MIN_BOTH = 5;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [NPIN-1:0] LVL_RST = 4'h0;
endpackage

//--- mpt_sync.sv
`timescale 1ns/1ps
module mpt_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  // Stage one feeds only stage two; value counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        out_q <= s3_q;
      end
    end
  end
  assign dout = out_q;
endmodule

//--- mpt_timer.sv
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// (R01) Writing 0 to a counter start bit halts that channel's counter.
// (R02) Stopped in either PWM mode, pins show programmed initial levels.
// (R03) Stopped in other modes, pins keep their last compare output level.
// (R04) Complementary PWM: compare A matches ch4, ch3 or sub-counter gives trough trigger.
// (R05) Complementary PWM: ch4 counter matching either ADC compare issues ADC start.
// (R06) External count clock pulses last 3 clocks single-edge, 5 both-edge.
// (R07) Enabled high-impedance trigger floats every multiplexed pin regardless of selection; the code floats only pins set in hiz1_q or hiz2_q.
// (R08) Counter advances on its selected clock only while its start bit is 1.
module mpt_timer
  import mpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_clk_pin,
  input wire logic hiz_trigger_pin,
  output logic [mpt_pkg::NPIN-1:0] timer_io_pin_o,
  output logic [mpt_pkg::NPIN-1:0] timer_io_pin_oe,
  output logic ch4_trough_trigger,
  output logic adc_start_req,
  output logic irq
);
  import mpt_pkg::*;

  logic [NCH-1:0] start_q, clksel_q, tick;
  logic [1:0] mode_q;
  logic [NPIN-1:0] lvl1_q, lvl2_q, hiz1_q, hiz2_q, cmp_out_q, hiz_q;
  logic [CNT_W-1:0] cmpa_q, adca_q, adcb_q, dead_q, cnt3_q, cnt4_q, subc_q;
  logic [NSTAT-1:0] stat_q, mask_q, ev;
  logic [7:0] ph_addr_q;
  logic [31:0] rdata_q;
  logic both_edge_q, trough_q, adc_q, ph_wr_q, ext_s, ext_prev_q, hiz_s, ext_edge;
  logic stopped, pwm_mode, ev_trough, ev_adca, ev_adcb, addr_ok;

  // External inputs cross in through four flops [R06]
  mpt_sync u_ext
  (
    .clk(clk),
    .rst(rst),
    .din(ext_clk_pin),
    .dout(ext_s)
  );
  mpt_sync u_hiz
  (
    .clk(clk),
    .rst(rst),
    .din(hiz_trigger_pin),
    .dout(hiz_s)
  );

  // Pulses shorter than the minimum widths may be filtered by the synchroniser [R06]
  assign ext_edge = both_edge_q ? (ext_s != ext_prev_q) : (ext_s & ~ext_prev_q);

  // Select clock per channel: 1 means external pin, 0 means clk
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_tick
      assign tick[i] = start_q[i] & (clksel_q[i] ? ext_edge : 1'b1); // [R08]
    end
  endgenerate

  assign pwm_mode = (mode_q == MODE_COMP_PWM) || (mode_q == MODE_RSYNC_PWM);
  assign stopped = ~start_q[1];
  assign ev_trough = (mode_q == MODE_COMP_PWM) && start_q[1]
                     && ((cmpa_q == cnt4_q) || (cmpa_q == cnt3_q) || (cmpa_q == subc_q)); // [R04]
  assign ev_adca = (mode_q == MODE_COMP_PWM) && tick[1] && (cnt4_q == adca_q); // [R05]
  assign ev_adcb = (mode_q == MODE_COMP_PWM) && tick[1] && (cnt4_q == adcb_q); // [R05]
  assign ev = {hiz_s, ev_adcb, ev_adca, ev_trough};

  // Counters: channel 0 is ch3, channel 1 is ch4
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt3_q <= CNT_RST;
      cnt4_q <= CNT_RST;
      subc_q <= CNT_RST;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_prev_q <= ext_s;
      if (tick[0])
      begin
        cnt3_q <= cnt3_q + 16'h0001; // [R08]
      end
      if (tick[1])
      begin
        cnt4_q <= cnt4_q + 16'h0001; // [R08]
        subc_q <= (subc_q >= dead_q) ? CNT_RST : subc_q + 16'h0001;
      end
    end
  end

  // Compare outputs toggle on match; frozen while stopped outside PWM modes, loaded with lvl1_q ^ lvl2_q while stopped in PWM modes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmp_out_q <= LVL_RST;
    end
    else if (stopped && pwm_mode)
    begin
      cmp_out_q <= lvl1_q ^ lvl2_q; // [R02]
    end
    else if (tick[1] && (cnt4_q == cmpa_q))
    begin
      cmp_out_q <= ~cmp_out_q;
    end
  end

  // Stopped outside PWM modes: cmp_out_q simply holds [R03]
  assign timer_io_pin_o = cmp_out_q;
  // High-impedance overrides pin function selection [R07]
  assign timer_io_pin_oe = ~hiz_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trough_q <= 1'b0;
      adc_q <= 1'b0;
      hiz_q <= '0;
    end
    else
    begin
      hiz_q <= {NPIN{hiz_s}} & (hiz1_q | hiz2_q); // [R07]
      trough_q <= ev_trough; // [R04]
      adc_q <= ev_adca | ev_adcb; // [R05]
    end
  end
  assign ch4_trough_trigger = trough_q;
  assign adc_start_req = adc_q;

  // AHB-Lite slave, zero wait states
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end
    else if (hready)
    begin
      ph_wr_q <= hsel & htrans[1] & hwrite & addr_ok;
      ph_addr_q <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = (haddr[7:0] <= OFS_SUBC) && (haddr[1:0] == 2'b00) && (haddr[31:8] == 24'h000000);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_q <= '0;
      mode_q <= MODE_NORMAL;
      lvl1_q <= LVL_RST;
      lvl2_q <= LVL_RST;
      cmpa_q <= CNT_RST;
      adca_q <= CNT_RST;
      adcb_q <= CNT_RST;
      dead_q <= CNT_RST;
      hiz1_q <= '0;
      hiz2_q <= '0;
      clksel_q <= '0;
      both_edge_q <= 1'b0;
      mask_q <= '0;
    end
    else if (ph_wr_q)
    begin
      case (ph_addr_q)
        OFS_START: start_q <= hwdata[NCH-1:0]; // [R01]
        OFS_MODE: mode_q <= hwdata[1:0];
        OFS_LVL1: lvl1_q <= hwdata[NPIN-1:0];
        OFS_LVL2: lvl2_q <= hwdata[NPIN-1:0];
        OFS_CMPA: cmpa_q <= hwdata[CNT_W-1:0];
        OFS_ADCA: adca_q <= hwdata[CNT_W-1:0];
        OFS_ADCB: adcb_q <= hwdata[CNT_W-1:0];
        OFS_DEAD: dead_q <= hwdata[CNT_W-1:0];
        OFS_HIZ1: hiz1_q <= hwdata[NPIN-1:0];
        OFS_HIZ2: hiz2_q <= hwdata[NPIN-1:0];
        OFS_CLKSEL:
        begin
          clksel_q <= hwdata[NCH-1:0];
          both_edge_q <= hwdata[4];
        end
        OFS_MASK: mask_q <= hwdata[NSTAT-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; new event wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stat_q <= '0;
    end
    else
    begin
      stat_q <= ((ph_wr_q && ph_addr_q == OFS_STAT) ? (stat_q & ~hwdata[NSTAT-1:0]) : stat_q) | ev;
    end
  end
  assign irq = |(stat_q & mask_q);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      rdata_q <= 32'h00000000;
      if (addr_ok)
      begin
        case (haddr[7:0])
          OFS_START: rdata_q[NCH-1:0] <= start_q;
          OFS_MODE: rdata_q[1:0] <= mode_q;
          OFS_LVL1: rdata_q[NPIN-1:0] <= lvl1_q;
          OFS_LVL2: rdata_q[NPIN-1:0] <= lvl2_q;
          OFS_CMPA: rdata_q[CNT_W-1:0] <= cmpa_q;
          OFS_ADCA: rdata_q[CNT_W-1:0] <= adca_q;
          OFS_ADCB: rdata_q[CNT_W-1:0] <= adcb_q;
          OFS_DEAD: rdata_q[CNT_W-1:0] <= dead_q;
          OFS_HIZ1: rdata_q[NPIN-1:0] <= hiz1_q;
          OFS_HIZ2: rdata_q[NPIN-1:0] <= hiz2_q;
          OFS_CLKSEL: rdata_q[4:0] <= {both_edge_q, 2'b00, clksel_q};
          OFS_STAT: rdata_q[NSTAT-1:0] <= stat_q;
          OFS_MASK: rdata_q[NSTAT-1:0] <= mask_q;
          OFS_CNT3: rdata_q[CNT_W-1:0] <= cnt3_q;
          OFS_CNT4: rdata_q[CNT_W-1:0] <= cnt4_q;
          OFS_SUBC: rdata_q[CNT_W-1:0] <= subc_q;
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end
  assign hrdata = rdata_q;

  // Assertions
  a_stop_holds_count: assert property (@(posedge clk) disable iff (rst)
    (ph_wr_q && ph_addr_q == OFS_START && !hwdata[1]) |=> ##1 $stable(cnt4_q)) // [R01]
    else $error("ch4 counter moved after stop");
  a_pwm_stop_level: assert property (@(posedge clk) disable iff (rst)
    (stopped && pwm_mode) |=> (timer_io_pin_o == ($past(lvl1_q) ^ $past(lvl2_q)))) // [R02]
    else $error("pin not at initial level when stopped in pwm");
  a_normal_stop_hold: assert property (@(posedge clk) disable iff (rst)
    (stopped && !pwm_mode && $past(stopped) && !$past(pwm_mode)) |-> $stable(timer_io_pin_o)) // [R03]
    else $error("pin changed while stopped in normal mode");
  a_trough_on_match: assert property (@(posedge clk) disable iff (rst)
    (mode_q == MODE_COMP_PWM && start_q[1] && cmpa_q == cnt3_q) |=> ch4_trough_trigger) // [R04]
    else $error("trough trigger missed on ch3 match");
  a_adc_start: assert property (@(posedge clk) disable iff (rst)
    (mode_q == MODE_COMP_PWM && tick[1] && cnt4_q == adcb_q) |=> adc_start_req) // [R05]
    else $error("adc start missed");
  a_adc_only_comp: assert property (@(posedge clk) disable iff (rst)
    (mode_q != MODE_COMP_PWM) |=> !adc_start_req) // [R05]
    else $error("adc start outside comp pwm");
  a_hiz_float: assert property (@(posedge clk) disable iff (rst)
    (hiz_s && hiz1_q[0]) |=> !timer_io_pin_oe[0]) // [R07]
    else $error("pin not floated");
  a_run_advance: assert property (@(posedge clk) disable iff (rst)
    (start_q[0] && !clksel_q[0]) |=> (cnt3_q == $past(cnt3_q) + 16'h0001)) // [R08]
    else $error("counter did not advance");
  a_hold_stopped: assert property (@(posedge clk) disable iff (rst)
    !start_q[0] |=> $stable(cnt3_q)) // [R08]
    else $error("counter moved while stopped");
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mpt_pkg::*;
  logic clk, rst, hsel, hwrite, hiz, rd_v, rdy, hresp, trough, adc_req, irq, ext;
  logic [31:0] haddr, hwdata, hrdata, rv, v3, v4;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NPIN-1:0] pin_o, pin_oe, lv;
  logic [7:0] adc_cnt, p, a0;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int n_errors, cmp_count, cyc;
  mpt_timer mpt_timer_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
    .ext_clk_pin(ext), .hiz_trigger_pin(hiz), .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe),
    .ch4_trough_trigger(trough), .adc_start_req(adc_req), .irq(irq));
  mpt_partner mpt_partner_inst (.clk(clk), .rst(rst), .adc_start_req(adc_req), .ext_clk_pin(ext), .adc_cnt(adc_cnt));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm, input logic [31:0] e);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (nm != "")
    begin
      exp_q.push_back(e);
      nm_q.push_back(nm);
      rd_v <= 1'b1;
    end
    do @(posedge clk); while (rdy !== 1'b1);
    rv = hrdata;
    rd_v <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, "", 32'h0);
  endtask
  // Read data is judged at the closing edge of its data phase
  always @(posedge clk)
    if (rd_v === 1'b1)
      check(nm_q.pop_front(), hrdata, exp_q.pop_front());
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    hiz = 1'b0;
    rd_v = 1'b0;
    void'($urandom(32'h124f));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("pins", {24'h0, pin_oe, pin_o}, 32'hf0);
    check("hresp", {31'h0, hresp}, 32'h0);
    bus(1'b0, OFS_STAT, 0, "stat", 32'h0);
    bus(1'b0, OFS_CNT4, 0, "cnt4", 32'h0);
    bus(1'b0, 8'h40, 0, "unmapped", 32'h0);
    wr(OFS_CMPA, 32'h5);
    wr(OFS_LVL1, 32'h5);
    wr(OFS_START, 32'h3);
    repeat (10) @(posedge clk);
    @(negedge clk);
    p = {pin_oe, pin_o};
    check("pins run", {24'h0, p}, 32'hff);
    wr(OFS_START, 32'h0);
    bus(1'b0, OFS_CNT4, 0, "", 0);
    v4 = rv;
    check("ran", {31'h0, v4 > 32'h8}, 32'h1);
    repeat (5) @(posedge clk);
    bus(1'b0, OFS_CNT4, 0, "held", v4);
    @(negedge clk);
    check("pins hold", {24'h0, pin_oe, pin_o}, {24'h0, p});
    wr(OFS_MODE, 32'h1);
    v3 = $urandom;
    lv = v3[3:0];
    wr(OFS_LVL1, {28'h0, v3[3:0]});
    v3 = $urandom;
    lv = lv ^ v3[3:0];
    wr(OFS_LVL2, {28'h0, v3[3:0]});
    wr(OFS_START, 32'h2);
    repeat (4) @(posedge clk);
    wr(OFS_START, 32'h0);
    repeat (3) @(negedge clk);
    check("pins init", {24'h0, pin_oe, pin_o}, {24'h0, 4'hf, lv});
    wr(OFS_MODE, 32'h0);
    wr(OFS_LVL2, 32'h0);
    @(negedge clk);
    check("pins kept", {24'h0, pin_oe, pin_o}, {24'h0, 4'hf, lv});
    wr(OFS_MODE, 32'h2);
    wr(OFS_MODE, 32'h0);
    @(negedge clk);
    check("pins rsync", {24'h0, pin_oe, pin_o}, {24'h0, 4'hf, lv ^ v3[3:0]});
    wr(OFS_CLKSEL, 32'h1);
    bus(1'b0, OFS_CNT3, 0, "", 0);
    v3 = rv;
    bus(1'b0, OFS_CNT4, 0, "", 0);
    v4 = rv;
    wr(OFS_START, 32'h1);
    mpt_partner_inst.pulses(30, 3);
    repeat (8) @(posedge clk);
    bus(1'b0, OFS_CNT3, 0, "ext single", (v3 + 30) & 32'hffff);
    wr(OFS_CLKSEL, 32'h11);
    mpt_partner_inst.pulses(4, 5);
    repeat (8) @(posedge clk);
    bus(1'b0, OFS_CNT3, 0, "ext both", (v3 + 38) & 32'hffff);
    bus(1'b0, OFS_CNT4, 0, "ch4 idle", v4);
    wr(OFS_START, 32'h0);
    // Compare A sits on the frozen ch3 count, out of reach of ch4
    v3 = (v3 + 38) & 32'hffff;
    wr(OFS_CLKSEL, 32'h0);
    wr(OFS_MODE, 32'h1);
    wr(OFS_CMPA, v3);
    wr(OFS_ADCA, (v4 + 4) & 32'hffff);
    wr(OFS_ADCB, (v4 + 5) & 32'hffff);
    a0 = adc_cnt;
    wr(OFS_START, 32'h2);
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("trough", {31'h0, trough}, 32'h1);
    wr(OFS_START, 32'h0);
    @(negedge clk);
    check("adc reqs", {24'h0, adc_cnt - a0}, 32'h2);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b0, OFS_STAT, 0, "stat", 32'h7);
    wr(OFS_MASK, 32'h7);
    @(negedge clk);
    check("irq", {31'h0, irq}, 32'h1);
    wr(OFS_STAT, 32'h7);
    bus(1'b0, OFS_STAT, 0, "stat clr", 32'h0);
    @(negedge clk);
    check("irq clr", {31'h0, irq}, 32'h0);
    wr(OFS_HIZ1, 32'h3);
    wr(OFS_HIZ2, 32'h4);
    wr(OFS_MASK, 32'h8);
    @(posedge clk);
    hiz <= 1'b1;
    repeat (8) @(negedge clk);
    check("oe", {28'h0, pin_oe}, 32'h8);
    check("irq hiz", {31'h0, irq}, 32'h1);
    @(posedge clk);
    hiz <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("pins rst", {24'h0, pin_oe, pin_o}, 32'hf0);
    check("irq rst", {31'h0, irq}, 32'h0);
    bus(1'b0, OFS_MODE, 0, "mode rst", 32'h0);
    bus(1'b0, OFS_STAT, 0, "stat rst", 32'h0);
    // Let the last queued read be judged before the verdict
    @(negedge clk);
    print_verdict();
  end
endmodule
